// ---- hw/status_event_pkg.sv ----
// Package with bit positions, masks, reset values and widths for the status reporting block.
package status_event_pkg;
    localparam int BYTE_W = 8;
    localparam int DIGIT_W = 4;
    localparam int VALUE_W_DEFAULT = 16;
    // Event flag bit positions.
    localparam int OPERATION_COMPLETE_BIT = 0;
    localparam int QUERY_ERROR_BIT = 2;
    localparam int DEVICE_DEPENDENT_ERROR_BIT = 3;
    localparam int EXECUTION_ERROR_BIT = 4;
    localparam int COMMAND_ERROR_BIT = 5;
    localparam int POWER_ON_BIT = 7;
    // Summary byte bit positions.
    localparam int MESSAGE_AVAILABLE_BIT = 4;
    localparam int EVENT_SUMMARY_BIT = 5;
    localparam int MASTER_SUMMARY_BIT = 6;
    // Masks and reset values.
    localparam logic [7:0] EVENT_FLAGS_USED = 8'hbd;
    localparam logic [7:0] SERVICE_MASK_USED = 8'hbe;
    localparam logic [7:0] SERVICE_MASK_STORED = 8'hbf;
    localparam logic [7:0] EVENT_FLAGS_RESET = 8'h80;
    localparam logic [7:0] EVENT_FLAG_ENABLE_RESET = 8'h00;
    localparam logic [7:0] SERVICE_MASK_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] DIGIT_ADJUST_LIMIT = 4'h5;
    localparam logic [3:0] DIGIT_ADJUST = 4'h3;
endpackage

// ---- hw/decimal_digits.sv ----
// Converts an 8-bit register value into three decimal digits.
`timescale 1ns/100ps
module decimal_digits
    import status_event_pkg::*;
(
    // Binary value.
    input wire logic [7:0] value,
    // Decimal digits.
    output logic [3:0] hundreds,
    output logic [3:0] tens,
    output logic [3:0] ones
);
    logic [19:0] shift;

    always_comb begin
        shift = 20'h00000;
        shift[7:0] = value;
        for (int i = 0; i < BYTE_W; i++) begin
            if (shift[11:8] >= DIGIT_ADJUST_LIMIT) begin
                shift[11:8] = shift[11:8] + DIGIT_ADJUST;
            end
            if (shift[15:12] >= DIGIT_ADJUST_LIMIT) begin
                shift[15:12] = shift[15:12] + DIGIT_ADJUST;
            end
            shift = shift << 1;
        end
        hundreds = shift[19:16];
        tens = shift[15:12];
        ones = shift[11:8];
    end
endmodule

// ---- hw/status_event_summary.sv ----
// Event flags, enables, summary byte, service mask and serial poll reporting.
`timescale 1ns/100ps
// Summary of operation
// (R1) Event flags latch until read or cleared.
// (R2) Event enable masks each flag from summary.
// (R3) Enabled flag rising sets event summary bit.
// (R4) Flags query or clear status drops summary.
// (R5) Bit 0 set when operation complete.
// (R6) Bit 2 set on query errors.
// (R7) Bit 3 set on calibration or overflow.
// (R8) Bit 4 set on unexecutable command.
// (R9) Bit 5 set on unparseable command.
// (R10) Bit 7 set after power cycle.
// (R11) Summary byte: eight bits, event summary bit 5.
// (R12) Bit 4 message available follows output buffer.
// (R13) Bit 6 master summary of enabled bits.
// (R14) Service mask covers bits 1-5 and 7.
// (R15) Serial poll bit 6 is request service.
// (R16) Summary query unchanged, bit 6 master summary.
// (R17) Values exchanged as decimal of 8 bits.
// (R18) Flags query returns flags then clears them.
// (R19) Clear status clears events; message conditionally.
// (R20) Service mask ignores and reads bit 6 zero.
// (R21) Enable values above 255 raise execution error.
// (R22) Unused event flag and summary byte bit positions always read zero.
module status_event_summary
    import status_event_pkg::*;
#(
    parameter int VALUE_W = VALUE_W_DEFAULT
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Event sources.
    input wire logic operationComplete,
    input wire logic readWithoutOutput,
    input wire logic lineBeforeRead,
    input wire logic buffersFull,
    input wire logic calibrationInputError,
    input wire logic inputOverflow,
    input wire logic parameterError,
    input wire logic syntaxError,
    input wire logic frontPanelService,
    // Output buffer state.
    input wire logic responsePlaced,
    input wire logic terminatorSent,
    // Commands from the parser.
    input wire logic summaryByteQuery,
    input wire logic eventFlagsQuery,
    input wire logic eventEnableQuery,
    input wire logic serviceMaskQuery,
    input wire logic clearStatusCommand,
    input wire logic clearStatusFirst,
    input wire logic eventEnableWrite,
    input wire logic serviceMaskWrite,
    input wire logic [VALUE_W-1:0] writeValue,
    input wire logic serialPoll,
    // Query response.
    output logic respValid,
    output logic [7:0] respByte,
    output logic [3:0] respHundreds,
    output logic [3:0] respTens,
    output logic [3:0] respOnes,
    // Serial poll answer and service request.
    output logic pollValid,
    output logic [7:0] pollByte,
    output logic serviceRequest
);
    logic [7:0] eventFlags_q, eventFlags_d;
    logic [7:0] eventFlagEnable_q, eventFlagEnable_d;
    logic [7:0] serviceMask_q, serviceMask_d;
    logic eventSummary_q, eventSummary_d;
    logic messageAvailable_q, messageAvailable_d;
    logic masterPrev_q, masterPrev_d;
    logic requestService_q, requestService_d;
    logic respValid_q, respValid_d;
    logic [7:0] respByte_q, respByte_d;
    logic [3:0] respHundreds_q, respHundreds_d;
    logic [3:0] respTens_q, respTens_d;
    logic [3:0] respOnes_q, respOnes_d;
    logic pollValid_q, pollValid_d;
    logic [7:0] pollByte_q, pollByte_d;
    logic [7:0] eventSet;
    logic [7:0] flagsBefore;
    logic [7:0] summaryByte;
    logic [3:0] digitHundreds, digitTens, digitOnes;
    logic clearFlags;
    logic badEnableValue;
    logic anyEnableWrite;
    logic masterSummary;
    logic masterRise;

    // Event sources and clears.
    always_comb begin
        anyEnableWrite = eventEnableWrite | serviceMaskWrite;
        badEnableValue = anyEnableWrite & (|writeValue[VALUE_W-1:BYTE_W]); // [R21]
        clearFlags = eventFlagsQuery | clearStatusCommand; // [R18] [R19]
        eventSet = BYTE_ZERO;
        eventSet[OPERATION_COMPLETE_BIT] = operationComplete; // [R5]
        eventSet[QUERY_ERROR_BIT] = readWithoutOutput | lineBeforeRead | buffersFull; // [R6]
        eventSet[DEVICE_DEPENDENT_ERROR_BIT] = calibrationInputError | inputOverflow; // [R7]
        eventSet[EXECUTION_ERROR_BIT] = parameterError | badEnableValue; // [R8] [R21]
        eventSet[COMMAND_ERROR_BIT] = syntaxError; // [R9]
        eventSet = eventSet & EVENT_FLAGS_USED; // [R22]
        flagsBefore = clearFlags ? BYTE_ZERO : eventFlags_q;
    end

    // Event flags, enable and event summary.
    always_comb begin
        eventFlags_d = flagsBefore | eventSet; // [R1] [R18]
        eventFlagEnable_d = eventFlagEnable_q;
        if (eventEnableWrite && !badEnableValue) begin
            eventFlagEnable_d = writeValue[7:0]; // [R2]
        end
        eventSummary_d = eventSummary_q & ~clearFlags; // [R4]
        if (|(eventSet & ~flagsBefore & eventFlagEnable_q)) begin
            eventSummary_d = 1'b1; // [R2] [R3]
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            eventFlags_q <= EVENT_FLAGS_RESET; // [R10]
            eventFlagEnable_q <= EVENT_FLAG_ENABLE_RESET;
            eventSummary_q <= 1'b0;
        end else begin
            eventFlags_q <= eventFlags_d;
            eventFlagEnable_q <= eventFlagEnable_d;
            eventSummary_q <= eventSummary_d;
        end
    end

    // Summary byte, service mask and request service.
    always_comb begin
        summaryByte = BYTE_ZERO; // [R22]
        summaryByte[MESSAGE_AVAILABLE_BIT] = messageAvailable_q;
        summaryByte[EVENT_SUMMARY_BIT] = eventSummary_q; // [R11]
        masterSummary = |(summaryByte & serviceMask_q & SERVICE_MASK_USED); // [R13] [R14]
        summaryByte[MASTER_SUMMARY_BIT] = masterSummary;
        masterRise = masterSummary & ~masterPrev_q;
        serviceMask_d = serviceMask_q;
        if (serviceMaskWrite && !badEnableValue) begin
            serviceMask_d = writeValue[7:0] & SERVICE_MASK_STORED; // [R20]
        end
        messageAvailable_d = messageAvailable_q;
        if (terminatorSent || (clearStatusCommand && clearStatusFirst)) begin
            messageAvailable_d = 1'b0; // [R12] [R19]
        end
        if (responsePlaced) begin
            messageAvailable_d = 1'b1; // [R12]
        end
        masterPrev_d = masterSummary;
        requestService_d = requestService_q & ~serialPoll; // [R15]
        if (frontPanelService || masterRise) begin
            requestService_d = 1'b1; // [R15]
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            serviceMask_q <= SERVICE_MASK_RESET;
            messageAvailable_q <= 1'b0;
            masterPrev_q <= 1'b0;
            requestService_q <= 1'b0;
        end else begin
            serviceMask_q <= serviceMask_d;
            messageAvailable_q <= messageAvailable_d;
            masterPrev_q <= masterPrev_d;
            requestService_q <= requestService_d;
        end
    end

    // Query answers and serial poll.
    always_comb begin
        respValid_d = 1'b1;
        if (eventFlagsQuery) begin
            respByte_d = eventFlags_q; // [R18]
        end else if (summaryByteQuery) begin
            respByte_d = summaryByte; // [R16]
        end else if (eventEnableQuery) begin
            respByte_d = eventFlagEnable_q;
        end else if (serviceMaskQuery) begin
            respByte_d = serviceMask_q; // [R20]
        end else begin
            respValid_d = 1'b0;
            respByte_d = respByte_q;
        end
        pollValid_d = serialPoll;
        pollByte_d = pollByte_q;
        if (serialPoll) begin
            pollByte_d = summaryByte;
            pollByte_d[MASTER_SUMMARY_BIT] = requestService_q; // [R15]
        end
    end

    decimal_digits digits (
        .value(respByte_d),
        .hundreds(digitHundreds),
        .tens(digitTens),
        .ones(digitOnes)
    );

    always_comb begin
        respHundreds_d = digitHundreds; // [R17]
        respTens_d = digitTens;
        respOnes_d = digitOnes;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            respValid_q <= 1'b0;
            respByte_q <= BYTE_ZERO;
            respHundreds_q <= 4'h0;
            respTens_q <= 4'h0;
            respOnes_q <= 4'h0;
            pollValid_q <= 1'b0;
            pollByte_q <= BYTE_ZERO;
        end else begin
            respValid_q <= respValid_d;
            respByte_q <= respByte_d;
            respHundreds_q <= respHundreds_d;
            respTens_q <= respTens_d;
            respOnes_q <= respOnes_d;
            pollValid_q <= pollValid_d;
            pollByte_q <= pollByte_d;
        end
    end

    assign respValid = respValid_q;
    assign respByte = respByte_q;
    assign respHundreds = respHundreds_q;
    assign respTens = respTens_q;
    assign respOnes = respOnes_q;
    assign pollValid = pollValid_q;
    assign pollByte = pollByte_q;
    assign serviceRequest = requestService_q;

    // Checks on the logic above.
    flags_hold_a: assert property (@(posedge clk) disable iff (reset) // [R1]
        !clearFlags |=> ((eventFlags_q & $past(eventFlags_q)) == $past(eventFlags_q)))
        else $error("event flag dropped without a read or clear");

    summary_rise_a: assert property (@(posedge clk) disable iff (reset) // [R3]
        (|(eventSet & ~eventFlags_q & eventFlagEnable_q)) |=> eventSummary_q)
        else $error("enabled flag rise did not set event summary");

    masked_rise_a: assert property (@(posedge clk) disable iff (reset) // [R2]
        (!eventSummary_q && !(|(eventSet & eventFlagEnable_q))) |=> !eventSummary_q)
        else $error("masked event set the event summary");

    read_clear_a: assert property (@(posedge clk) disable iff (reset) // [R18]
        (eventFlagsQuery && eventSet == BYTE_ZERO)
        |=> (eventFlags_q == BYTE_ZERO) && !eventSummary_q && respValid_q
            && respByte_q == $past(eventFlags_q))
        else $error("flags query did not return and clear flags");

    clear_status_a: assert property (@(posedge clk) disable iff (reset) // [R4]
        (clearStatusCommand && eventSet == BYTE_ZERO) |=> !eventSummary_q && eventFlags_q == 8'h00)
        else $error("clear status left events set");

    opc_set_a: assert property (@(posedge clk) disable iff (reset) // [R5]
        operationComplete |=> eventFlags_q[OPERATION_COMPLETE_BIT])
        else $error("operation complete flag not set");

    query_err_a: assert property (@(posedge clk) disable iff (reset) // [R6]
        (readWithoutOutput || lineBeforeRead || buffersFull) |=> eventFlags_q[QUERY_ERROR_BIT])
        else $error("query error flag not set");

    dev_err_a: assert property (@(posedge clk) disable iff (reset) // [R7]
        (calibrationInputError || inputOverflow) |=> eventFlags_q[DEVICE_DEPENDENT_ERROR_BIT])
        else $error("device dependent error flag not set");

    cmd_err_a: assert property (@(posedge clk) disable iff (reset) // [R9]
        syntaxError |=> eventFlags_q[COMMAND_ERROR_BIT])
        else $error("command error flag not set");

    bad_value_a: assert property (@(posedge clk) disable iff (reset) // [R21]
        (eventEnableWrite && |writeValue[VALUE_W-1:BYTE_W])
        |=> eventFlags_q[EXECUTION_ERROR_BIT] && eventFlagEnable_q == $past(eventFlagEnable_q))
        else $error("out of range enable value not refused");

    mav_track_a: assert property (@(posedge clk) disable iff (reset) // [R12]
        responsePlaced |=> messageAvailable_q)
        else $error("message available not set by a placed response");

    mav_clear_a: assert property (@(posedge clk) disable iff (reset) // [R12]
        (terminatorSent && !responsePlaced) |=> !messageAvailable_q)
        else $error("message available not cleared by the terminator");

    exe_err_a: assert property (@(posedge clk) disable iff (reset) // [R8]
        parameterError |=> eventFlags_q[EXECUTION_ERROR_BIT])
        else $error("execution error flag not set");

    rqs_set_a: assert property (@(posedge clk) disable iff (reset) // [R15]
        (frontPanelService || masterRise) |=> requestService_q)
        else $error("request service not raised");

    master_sum_a: assert property (@(posedge clk) disable iff (reset) // [R13]
        masterSummary == ((eventSummary_q && serviceMask_q[EVENT_SUMMARY_BIT])
            || (messageAvailable_q && serviceMask_q[MESSAGE_AVAILABLE_BIT])))
        else $error("master summary does not follow the enabled bits");

    cls_first_a: assert property (@(posedge clk) disable iff (reset) // [R19]
        (clearStatusCommand && clearStatusFirst && !responsePlaced) |=> !messageAvailable_q)
        else $error("leading clear status kept message available");

    cls_keep_a: assert property (@(posedge clk) disable iff (reset) // [R19]
        (clearStatusCommand && !clearStatusFirst && messageAvailable_q && !terminatorSent)
        |=> messageAvailable_q)
        else $error("clear status dropped message available");

    enable_write_a: assert property (@(posedge clk) disable iff (reset) // [R2]
        (eventEnableWrite && !(|writeValue[VALUE_W-1:BYTE_W]))
        |=> eventFlagEnable_q == $past(writeValue[7:0]))
        else $error("event enable write not stored");

    mask_write_a: assert property (@(posedge clk) disable iff (reset) // [R20]
        (serviceMaskWrite && !(|writeValue[VALUE_W-1:BYTE_W]))
        |=> serviceMask_q == {$past(writeValue[7]), 1'b0, $past(writeValue[5:0])})
        else $error("service mask write not stored without bit 6");

    stb_query_a: assert property (@(posedge clk) disable iff (reset) // [R16]
        (summaryByteQuery && !eventFlagsQuery)
        |=> respByte_q[MASTER_SUMMARY_BIT] == $past(masterSummary)
            && respByte_q[3:0] == 4'h0 && respByte_q[7] == 1'b0)
        else $error("summary query answer wrong");

    poll_clear_a: assert property (@(posedge clk) disable iff (reset) // [R15]
        (serialPoll && !frontPanelService && !masterRise)
        |=> !requestService_q && pollValid_q
            && pollByte_q[MASTER_SUMMARY_BIT] == $past(requestService_q))
        else $error("serial poll did not report and clear request service");

    mask_bit6_a: assert property (@(posedge clk) disable iff (reset) // [R20]
        serviceMask_q[MASTER_SUMMARY_BIT] == 1'b0)
        else $error("service mask holds bit 6");

    unused_zero_a: assert property (@(posedge clk) disable iff (reset) // [R22]
        (eventFlags_q & ~EVENT_FLAGS_USED) == BYTE_ZERO)
        else $error("unused event flag bit set");

    decimal_a: assert property (@(posedge clk) disable iff (reset) // [R17]
        respValid_q |-> (int'(respHundreds_q) * 100 + int'(respTens_q) * 10
            + int'(respOnes_q)) == int'(respByte_q))
        else $error("decimal digits do not match response byte");
endmodule

// ---- tb/host_model.sv ----
// Host model that sends register commands and decodes the decimal answers.
`timescale 1ns/100ps
module host_model (
    // Clock.
    input wire logic clk,
    // Command strobes and write value.
    output logic [7:0] cmd,
    output logic [15:0] writeValue,
    // Answers from the device.
    input wire logic respValid,
    input wire logic [3:0] respHundreds,
    input wire logic [3:0] respTens,
    input wire logic [3:0] respOnes,
    input wire logic pollValid,
    input wire logic [7:0] pollByte
);
    initial begin
        cmd = 8'h00;
        writeValue = 16'h0000;
    end
    // Pulses one strobe; the value is only meaningful with its strobe.
    task automatic send(input int idx, input logic [15:0] val);
        @(posedge clk);
        cmd[idx] <= 1'b1;
        writeValue <= val;
        @(posedge clk);
        cmd[idx] <= 1'b0;
        writeValue <= ~val;
    endtask
    // Sends a query and rebuilds the byte from its decimal digits.
    task automatic ask(input int idx, output logic [7:0] v);
        logic [31:0] n;
        send(idx, 16'h0000);
        #1;
        n = respHundreds * 100 + respTens * 10 + respOnes;
        v = (respValid === 1'b1) ? n[7:0] : 8'hxx;
    endtask
    // Takes a serial poll and returns the poll byte.
    task automatic poll(output logic [7:0] v);
        send(7, 16'h0000);
        #1;
        v = (pollValid === 1'b1) ? pollByte : 8'hxx;
    endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the status reporting block.
`timescale 1ns/100ps
module testbench;
    import status_event_pkg::*;
    localparam int QS = 0, QF = 1, QE = 2, QM = 3, CLR = 4, WE = 5, WM = 6;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] ev = 12'h000;
    logic [7:0] cmd;
    logic [15:0] writeValue;
    logic respValid, pollValid, serviceRequest;
    logic [7:0] respByte, pollByte, got;
    logic [3:0] hun, ten, one;
    int badCount = 0;
    int testsRun = 0;
    int evBit [8] = '{OPERATION_COMPLETE_BIT, QUERY_ERROR_BIT, QUERY_ERROR_BIT,
        QUERY_ERROR_BIT, DEVICE_DEPENDENT_ERROR_BIT, DEVICE_DEPENDENT_ERROR_BIT,
        EXECUTION_ERROR_BIT, COMMAND_ERROR_BIT};
    always #4 clk = ~clk;
    status_event_summary uut (
        .clk(clk), .reset(reset),
        .operationComplete(ev[0]), .readWithoutOutput(ev[1]),
        .lineBeforeRead(ev[2]), .buffersFull(ev[3]),
        .calibrationInputError(ev[4]), .inputOverflow(ev[5]),
        .parameterError(ev[6]), .syntaxError(ev[7]),
        .frontPanelService(ev[8]), .responsePlaced(ev[9]),
        .terminatorSent(ev[10]), .clearStatusFirst(ev[11]),
        .summaryByteQuery(cmd[0]), .eventFlagsQuery(cmd[1]),
        .eventEnableQuery(cmd[2]), .serviceMaskQuery(cmd[3]),
        .clearStatusCommand(cmd[4]), .eventEnableWrite(cmd[5]),
        .serviceMaskWrite(cmd[6]), .serialPoll(cmd[7]), .writeValue(writeValue),
        .respValid(respValid), .respByte(respByte), .respHundreds(hun),
        .respTens(ten), .respOnes(one), .pollValid(pollValid),
        .pollByte(pollByte), .serviceRequest(serviceRequest)
    );
    host_model host (
        .clk(clk), .cmd(cmd), .writeValue(writeValue), .respValid(respValid),
        .respHundreds(hun), .respTens(ten), .respOnes(one),
        .pollValid(pollValid), .pollByte(pollByte)
    );
    task automatic giveVerdict();
        $display("comparisons %0d, mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // Raises one event source for a single cycle.
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask
    // Queries a register and compares both the decimal answer and the byte.
    task automatic rd(input int idx, input logic [7:0] exp);
        host.ask(idx, got);
        check(got, exp);
        check(respByte, exp);
    endtask
    initial begin
        #20000;
        badCount++;
        giveVerdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd(QF, EVENT_FLAGS_RESET);
        rd(QF, 8'h00);
        rd(QS, 8'h00);
        rd(QE, EVENT_FLAG_ENABLE_RESET);
        rd(QM, SERVICE_MASK_RESET);
        for (int i = 0; i < 8; i++) begin
            pulse(i);
            rd(QF, 8'h01 << evBit[i]);
        end
        host.send(WE, 16'h0010);
        pulse(7);
        rd(QS, 8'h00);
        pulse(6);
        rd(QS, 8'h20);
        rd(QS, 8'h20);
        rd(QF, 8'h30);
        rd(QS, 8'h00);
        pulse(9);
        rd(QS, 8'h10);
        host.send(WM, 16'h00ff);
        rd(QM, 8'hbf);
        rd(QS, 8'h50);
        check({7'h00, serviceRequest}, 8'h01);
        host.poll(got);
        check(got, 8'h50);
        check({7'h00, serviceRequest}, 8'h00);
        host.poll(got);
        check(got, 8'h10);
        rd(QS, 8'h50);
        host.send(WM, 16'h0040);
        rd(QS, 8'h10);
        pulse(10);
        rd(QS, 8'h00);
        pulse(8);
        host.poll(got);
        check(got, 8'h40);
        // The host breaks its range limit here on purpose.
        host.send(WE, 16'h012c);
        rd(QE, 8'h10);
        rd(QF, 8'h10);
        host.send(WE, 16'h00ff);
        rd(QE, 8'hff);
        rd(QF, 8'h00);
        pulse(6);
        pulse(9);
        rd(QS, 8'h30);
        host.send(CLR, 16'h0000);
        rd(QS, 8'h10);
        rd(QF, 8'h00);
        @(posedge clk);
        ev[11] <= 1'b1;
        host.send(CLR, 16'h0000);
        rd(QS, 8'h00);
        giveVerdict();
    end
endmodule
